// File: rtl/iem_pkg.sv
// Purpose: Shared constants for the interrupt enable and mode configuration block
// Assumes: 16-bit host register words, word-indexed addresses
// Notes:   Event bit positions match the enable and status bit positions
package iem_pkg;
    // ==========================================================
    // Register addresses (word index on the host bus)
    localparam logic [4:0]  IEM_ADDR_MASK_ONE   = 5'h00;
    localparam logic [4:0]  IEM_ADDR_CONFIG_ONE = 5'h01;
    localparam logic [4:0]  IEM_ADDR_STATUS_ONE = 5'h06;
    localparam logic [4:0]  IEM_ADDR_CONFIG_THR = 5'h07;
    localparam logic [4:0]  IEM_ADDR_STATUS_TWO = 5'h1E;

    // ==========================================================
    // Reset values
    localparam logic [15:0] IEM_MASK_ONE_RST    = 16'h0000;
    localparam logic [15:0] IEM_CONFIG_ONE_RST  = 16'h8000;
    localparam logic [15:0] IEM_CONFIG_THR_RST  = 16'h0000;
    localparam logic [15:0] IEM_STATUS_RST      = 16'h0000;

    // ==========================================================
    // Interrupt enable bit positions
    localparam int IEM_BIT_MEM_PARITY   = 14;
    localparam int IEM_BIT_TX_TIMEOUT   = 13;
    localparam int IEM_BIT_CMD_WRAP     = 12;
    localparam int IEM_BIT_MON_CMD_WRAP = 11;
    localparam int IEM_BIT_MON_DAT_WRAP = 10;
    localparam int IEM_BIT_HANDSHAKE    = 9;
    localparam int IEM_BIT_RETRY        = 8;
    localparam int IEM_BIT_ADDR_PARITY  = 7;
    localparam int IEM_BIT_STAMP_WRAP   = 6;
    localparam int IEM_BIT_RING_WRAP    = 5;
    localparam int IEM_BIT_CW_MSG_END   = 4;
    localparam int IEM_BIT_FRAME_END    = 3;
    localparam int IEM_BIT_MSG_ERROR    = 2;
    localparam int IEM_BIT_MODE_EVENT   = 1;
    localparam int IEM_BIT_MSG_END      = 0;
    localparam logic [15:0] IEM_MASK_WRITABLE = 16'h7FFF;

    // ==========================================================
    // Configuration one field positions
    localparam int IEM_CFG_ROLE_HI      = 15;
    localparam int IEM_CFG_ROLE_LO      = 14;
    localparam int IEM_CFG_MEM_SEL      = 13;
    localparam int IEM_CFG_HALT_FAULT   = 12;
    localparam logic [15:0] IEM_CFG_ENH_FIELDS = 16'h0FFF;

    // Configuration three enhanced-mode enable
    localparam int IEM_CFG3_ENHANCED    = 15;

    // Second status register: self-test done
    localparam int IEM_STAT2_SELFTEST   = 2;

    // Source selection for the mode-dependent event
    typedef enum logic [2:0] {
        IEM_SRC_CTRL    = 3'h1,
        IEM_SRC_TERM    = 3'h2,
        IEM_SRC_MONITOR = 3'h4
    } iem_src_t;
endpackage : iem_pkg

// File: rtl/iem_event_bit.sv
// Purpose: One sticky event flag with read-to-clear and interrupt gating
// Assumes: Clear pulse comes from a host read of the status register
// Notes:   A set arriving with the clear wins so no event is lost
`timescale 1ns/100ps
module iem_event_bit
(
    input  wire logic clk_sys_in,
    input  wire logic arst_n_in,
    input  wire logic event_in,
    input  wire logic clear_in,
    input  wire logic enable_in,
    output logic      flag_out,
    output logic      pending_out
);
    // ==========================================================
    // Sticky flag
    logic flag_reg;
    logic flag_next;

    // Set has priority over clear
    assign flag_next = event_in | (flag_reg & ~clear_in);

    // Flag register
    always_ff @(posedge clk_sys_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            flag_reg <= 1'b0;
        else
            flag_reg <= flag_next;
    end

    assign flag_out    = flag_reg;
    assign pending_out = flag_reg & enable_in;
endmodule : iem_event_bit

// File: rtl/iem_interrupt_config.sv
// Purpose: Interrupt enable register, first status register and legacy
//          controller configuration register for a dual-redundant terminal
// Assumes: Single-cycle host strobes synchronous to clk_sys_in
// Notes:   Event sources live outside; this block latches and gates them
//
// How it works
// - Enable one raises interrupt; zero masks it
// - Event sets status bit regardless of enable
// - Bit 14 gates memory parity error
// - Bit 13 gates transmitter timeout
// - Bit 12 gates active-role command stack wrap
// - Bit 11 gates monitor command stack wrap
// - Bit 10 gates monitor data stack wrap
// - Bit 9 gates external memory handshake failure
// - Bit 8 gates every controller retry
// - Bit 7 gates terminal address parity fail
// - Bit 6 gates time tag wraparound
// - Bit 5 gates terminal ring buffer wrap
// - Bit 4 gates control-word flagged message end
// - Bit 3 gates controller frame end
// - Bit 2 gates message error, loopback, timeout
// - Bit 1 trigger depends on operating mode
// - Bit 0 gates every message end
// - Config bit 15 resets one; bit14 zero
// - Config bit 13 selects memory location
// - Config bit 12 halts after faulty message
// - Enhanced mode needs cfg1.15 low, cfg3.15 high
// - Self-test done sets second status bit 2
`timescale 1ns/100ps
module iem_interrupt_config
#(
    parameter int EVENT_COUNT = 15
)
(
    input  wire logic        clk_sys_in,
    input  wire logic        arst_n_in,
    // Host register port
    input  wire logic [4:0]  host_addr_in,
    input  wire logic [15:0] host_wdata_in,
    input  wire logic        host_wr_in,
    input  wire logic        host_rd_in,
    output logic      [15:0] host_rdata_out,
    // Event sources
    input  wire logic        mem_parity_err_in,
    input  wire logic        transmitter_timeout_in,
    input  wire logic        cmd_stack_wrap_in,
    input  wire logic        monitor_cmd_wrap_in,
    input  wire logic        monitor_data_wrap_in,
    input  wire logic        ext_mem_handshake_fail_in,
    input  wire logic        controller_retry_in,
    input  wire logic        terminal_addr_parity_fail_in,
    input  wire logic        timestamp_wrap_in,
    input  wire logic        terminal_ring_wrap_in,
    input  wire logic        msg_end_in,
    input  wire logic        ctrlword_msg_end_flag_in,
    input  wire logic        controller_frame_end_in,
    input  wire logic        msg_error_in,
    input  wire logic        status_word_mismatch_in,
    input  wire logic        mode_command_in,
    input  wire logic        trigger_match_in,
    input  wire logic        selftest_done_in,
    input  wire logic        retry_success_in,
    // Outputs
    output logic             irq_out,
    output logic             role_select_hi_out,
    output logic             role_select_lo_out,
    output logic             memory_location_sel_out,
    output logic             halt_after_faulty_msg_out,
    output logic             enhanced_mode_out,
    output logic             controller_halt_out
);
    // ==========================================================
    // Registers
    logic [15:0] mask_one_reg;
    logic [15:0] config_one_reg;
    logic [15:0] config_thr_reg;
    logic        selftest_done_flag_reg;
    logic [15:0] rdata_reg;
    logic        irq_reg;
    logic        halt_reg;

    // ==========================================================
    // Address decode
    wire wr_mask   = host_wr_in & (host_addr_in == iem_pkg::IEM_ADDR_MASK_ONE);
    wire wr_cfg1   = host_wr_in & (host_addr_in == iem_pkg::IEM_ADDR_CONFIG_ONE);
    wire wr_cfg3   = host_wr_in & (host_addr_in == iem_pkg::IEM_ADDR_CONFIG_THR);
    wire rd_stat1  = host_rd_in & (host_addr_in == iem_pkg::IEM_ADDR_STATUS_ONE);
    wire rd_stat2  = host_rd_in & (host_addr_in == iem_pkg::IEM_ADDR_STATUS_TWO);

    // ==========================================================
    // Mode decode: controller when role bit high is clear
    wire ctrl_mode = ~config_one_reg[iem_pkg::IEM_CFG_ROLE_HI];
    wire enh_mode  = ctrl_mode & config_thr_reg[iem_pkg::IEM_CFG3_ENHANCED];
    wire term_mode = config_one_reg[iem_pkg::IEM_CFG_ROLE_HI] & ~config_one_reg[iem_pkg::IEM_CFG_ROLE_LO];
    wire mon_mode  = config_one_reg[iem_pkg::IEM_CFG_ROLE_HI] & config_one_reg[iem_pkg::IEM_CFG_ROLE_LO];

    // Mode-dependent event: one source per operating role
    wire mode_event = (ctrl_mode & status_word_mismatch_in)
                    | (term_mode & mode_command_in)
                    | (mon_mode  & trigger_match_in);

    // Event vector: bit index matches enable index
    wire [14:0] events;
    assign events[iem_pkg::IEM_BIT_MEM_PARITY]   = mem_parity_err_in;
    assign events[iem_pkg::IEM_BIT_TX_TIMEOUT]   = transmitter_timeout_in;
    assign events[iem_pkg::IEM_BIT_CMD_WRAP]     = cmd_stack_wrap_in;
    assign events[iem_pkg::IEM_BIT_MON_CMD_WRAP] = monitor_cmd_wrap_in;
    assign events[iem_pkg::IEM_BIT_MON_DAT_WRAP] = monitor_data_wrap_in;
    assign events[iem_pkg::IEM_BIT_HANDSHAKE]    = ext_mem_handshake_fail_in;
    assign events[iem_pkg::IEM_BIT_RETRY]        = controller_retry_in;
    assign events[iem_pkg::IEM_BIT_ADDR_PARITY]  = terminal_addr_parity_fail_in;
    assign events[iem_pkg::IEM_BIT_STAMP_WRAP]   = timestamp_wrap_in;
    assign events[iem_pkg::IEM_BIT_RING_WRAP]    = terminal_ring_wrap_in;
    assign events[iem_pkg::IEM_BIT_CW_MSG_END]   = msg_end_in & ctrlword_msg_end_flag_in;
    assign events[iem_pkg::IEM_BIT_FRAME_END]    = controller_frame_end_in;
    assign events[iem_pkg::IEM_BIT_MSG_ERROR]    = msg_error_in;
    assign events[iem_pkg::IEM_BIT_MODE_EVENT]   = mode_event;
    assign events[iem_pkg::IEM_BIT_MSG_END]      = msg_end_in;

    // ==========================================================
    // Per-event sticky flags; status is set whatever the enable
    wire [14:0] status_flags;
    wire [14:0] pending;
    genvar g;
    generate
        for (g = 0; g < EVENT_COUNT; g++)
        begin : g_evt
            iem_event_bit i_iem_event_bit
            (
                .clk_sys_in  (clk_sys_in),
                .arst_n_in   (arst_n_in),
                .event_in    (events[g]),
                .clear_in    (rd_stat1),
                .enable_in   (mask_one_reg[g]),
                .flag_out    (status_flags[g]),
                .pending_out (pending[g])
            );
        end
    endgenerate

    wire [15:0] status_one = {1'b0, status_flags};
    wire [15:0] status_two = {13'h0000, selftest_done_flag_reg, 2'h0};

    // ==========================================================
    // Read mux; unmapped addresses read zero
    logic [15:0] rdata_next;
    always_comb
    begin
        unique case (host_addr_in)
            iem_pkg::IEM_ADDR_MASK_ONE:   rdata_next = mask_one_reg;
            iem_pkg::IEM_ADDR_CONFIG_ONE: rdata_next = config_one_reg;
            iem_pkg::IEM_ADDR_CONFIG_THR: rdata_next = config_thr_reg;
            iem_pkg::IEM_ADDR_STATUS_ONE: rdata_next = status_one;
            iem_pkg::IEM_ADDR_STATUS_TWO: rdata_next = status_two;
            default:                      rdata_next = 16'h0000;
        endcase
    end

    // Config write: mode bit 14 forced clear in controller mode
    wire [15:0] cfg1_wr = host_wdata_in;
    wire        cfg1_wr_ctrl = ~cfg1_wr[iem_pkg::IEM_CFG_ROLE_HI];
    wire [15:0] cfg1_next = cfg1_wr_ctrl
                          ? (cfg1_wr & ~(16'h0001 << iem_pkg::IEM_CFG_ROLE_LO))
                          : cfg1_wr;

    // Reserved mask bit 15 stays zero; host keeps bit 14 low on 4K parts
    wire [15:0] mask_next = host_wdata_in & iem_pkg::IEM_MASK_WRITABLE;

    // ==========================================================
    // Host-writable registers
    always_ff @(posedge clk_sys_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            mask_one_reg   <= iem_pkg::IEM_MASK_ONE_RST;
            config_one_reg <= iem_pkg::IEM_CONFIG_ONE_RST;
            config_thr_reg <= iem_pkg::IEM_CONFIG_THR_RST;
        end
        else
        begin
            if (wr_mask)
                mask_one_reg <= mask_next;
            if (wr_cfg1)
                config_one_reg <= cfg1_next;
            if (wr_cfg3)
                config_thr_reg <= host_wdata_in;
        end
    end

    // Self-test flag: set wins over read clear
    always_ff @(posedge clk_sys_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            selftest_done_flag_reg <= 1'b0;
        else
            selftest_done_flag_reg <= selftest_done_in | (selftest_done_flag_reg & ~rd_stat2);
    end

    // ==========================================================
    // Halt request: faulty message with no successful retry
    wire halt_set = ctrl_mode & config_one_reg[iem_pkg::IEM_CFG_HALT_FAULT]
                  & msg_end_in & msg_error_in & ~retry_success_in;
    wire halt_clr = wr_cfg1 | ~ctrl_mode;

    // Output registers so every port comes from a flip-flop
    always_ff @(posedge clk_sys_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            rdata_reg <= 16'h0000;
            irq_reg   <= 1'b0;
            halt_reg  <= 1'b0;
        end
        else
        begin
            rdata_reg <= rdata_next;
            irq_reg   <= |pending;
            halt_reg  <= halt_set | (halt_reg & ~halt_clr);
        end
    end

    // ==========================================================
    // Port drive; config bits are register bits directly
    assign host_rdata_out            = rdata_reg;
    assign irq_out                   = irq_reg;
    assign controller_halt_out       = halt_reg;
    assign role_select_hi_out        = config_one_reg[iem_pkg::IEM_CFG_ROLE_HI];
    assign role_select_lo_out        = config_one_reg[iem_pkg::IEM_CFG_ROLE_LO];
    assign memory_location_sel_out   = config_one_reg[iem_pkg::IEM_CFG_MEM_SEL];
    assign halt_after_faulty_msg_out = config_one_reg[iem_pkg::IEM_CFG_HALT_FAULT];

    // Enhanced mode flag registered for a clean output
    logic enh_reg;
    always_ff @(posedge clk_sys_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            enh_reg <= 1'b0;
        else
            enh_reg <= enh_mode;
    end
    assign enhanced_mode_out = enh_reg;
endmodule : iem_interrupt_config

// File: test/iem_interrupt_config_props.sv
// Purpose: Port-level checks for the interrupt enable and configuration block
// Assumes: One clock domain, host strobes one cycle wide
// Notes:   The enable word is shadowed from host writes instead of peeked
`timescale 1ns/100ps
module iem_interrupt_config_props
(
    input  wire logic        clk_sys_in,
    input  wire logic        arst_n_in,
    input  wire logic [4:0]  host_addr_in,
    input  wire logic [15:0] host_wdata_in,
    input  wire logic        host_wr_in,
    input  wire logic        host_rd_in,
    input  wire logic [15:0] host_rdata_out,
    input  wire logic        mem_parity_err_in,
    input  wire logic        controller_retry_in,
    input  wire logic        msg_end_in,
    input  wire logic        msg_error_in,
    input  wire logic        retry_success_in,
    input  wire logic        selftest_done_in,
    input  wire logic        irq_out,
    input  wire logic        role_select_hi_out,
    input  wire logic        role_select_lo_out,
    input  wire logic        memory_location_sel_out,
    input  wire logic        halt_after_faulty_msg_out,
    input  wire logic        enhanced_mode_out,
    input  wire logic        controller_halt_out
);
    logic [15:0] en_reg;
    // ==========================================================
    // Enable shadow, bit 15 never sticks
    always_ff @(posedge clk_sys_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            en_reg <= iem_pkg::IEM_MASK_ONE_RST;
        else if (host_wr_in && host_addr_in == iem_pkg::IEM_ADDR_MASK_ONE)
            en_reg <= host_wdata_in & iem_pkg::IEM_MASK_WRITABLE;
    end
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!arst_n_in);
    // ==========================================================
    // Properties
    a_retry_irq_gate: assert property (controller_retry_in && en_reg[8] && !host_wr_in |-> ##2 irq_out)
        else $error("retry event with enable set gave no interrupt");
    a_parity_irq_gate: assert property (mem_parity_err_in && en_reg[14] && !host_wr_in |-> ##2 irq_out)
        else $error("parity event with enable set gave no interrupt");
    a_mask_read_back: assert property (host_rd_in && !host_wr_in && host_addr_in == 5'h00
        |=> host_rdata_out == $past(en_reg)) else $error("enable word read back wrong");
    a_status_sets: assert property (controller_retry_in ##1 (host_rd_in && host_addr_in == 5'h06)
        |=> host_rdata_out[8]) else $error("retry event not seen in status");
    a_cfg_fields: assert property (host_wr_in && host_addr_in == 5'h01 |=>
        memory_location_sel_out == $past(host_wdata_in[13]) && halt_after_faulty_msg_out == $past(host_wdata_in[12]))
        else $error("configuration fields did not follow write");
    a_ctrl_lo_zero: assert property (!role_select_hi_out |-> !role_select_lo_out)
        else $error("role low bit set in controller mode");
    a_reset_defaults: assert property ($rose(arst_n_in) |-> role_select_hi_out && !irq_out && !controller_halt_out)
        else $error("wrong values at reset release");
    a_enhanced_needs: assert property (enhanced_mode_out |-> !$past(role_select_hi_out))
        else $error("enhanced mode outside controller mode");
    a_halt_on_fault: assert property (!role_select_hi_out && halt_after_faulty_msg_out && msg_end_in
        && msg_error_in && !retry_success_in && !host_wr_in |-> ##[1:2] controller_halt_out)
        else $error("faulty message did not halt controller");
    a_halt_cause: assert property ($rose(controller_halt_out) |-> $past(msg_error_in) || $past(msg_error_in, 2))
        else $error("halt without message error");
    a_selftest_flag: assert property (selftest_done_in ##1 (host_rd_in && host_addr_in == 5'h1E)
        |=> host_rdata_out[2]) else $error("self-test flag not reported");
    c_irq_rise: cover property ($rose(irq_out));
    c_halt_seen: cover property (controller_halt_out);
    c_enh_seen: cover property (enhanced_mode_out);
endmodule : iem_interrupt_config_props
bind iem_interrupt_config iem_interrupt_config_props i_iem_interrupt_config_props (.*);

// File: test/iem_host_model.sv
// Purpose: Host processor model on the parallel register bus
// Assumes: Tasks are entered just after a falling clock edge
// Notes:   Write data is inverted once released so stale values never pass
`timescale 1ns/100ps
module iem_host_model
#(
    parameter bit SMALL_MEM = 1'b0
)
(
    input  wire logic        clk_sys_in,
    input  wire logic [15:0] host_rdata_in,
    output logic      [4:0]  host_addr_out,
    output logic      [15:0] host_wdata_out,
    output logic             host_wr_out,
    output logic             host_rd_out
);
    // Idle bus at time zero
    initial
    begin
        host_addr_out  = 5'h00;
        host_wdata_out = 16'h0000;
        host_wr_out    = 1'b0;
        host_rd_out    = 1'b0;
    end
    // ==========================================================
    // Bus cycles, one idle cycle after each
    task automatic write_word(input logic [4:0] addr, input logic [15:0] data);
        host_addr_out  = addr;
        host_wdata_out = (SMALL_MEM && addr == 5'h00) ? (data & 16'hBFFF) : data;
        host_wr_out    = 1'b1;
        @(negedge clk_sys_in);
        host_wr_out    = 1'b0;
        host_wdata_out = ~host_wdata_out;
        @(negedge clk_sys_in);
    endtask : write_word
    task automatic read_word(input logic [4:0] addr, output logic [15:0] data);
        host_addr_out = addr;
        host_rd_out   = 1'b1;
        @(negedge clk_sys_in);
        data          = host_rdata_in;
        host_rd_out   = 1'b0;
        @(negedge clk_sys_in);
    endtask : read_word
endmodule : iem_host_model

// File: test/iem_interrupt_config_tb_top.sv
// Purpose: Self-checking bench for the interrupt enable and configuration block
// Assumes: Inputs change on the falling clock edge
// Notes:   Bit 1 events use the terminal-mode source unless the mode is swept
`timescale 1ns/100ps
module iem_interrupt_config_tb_top;
    logic        clk_sys_in, arst_n_in, host_wr_in, host_rd_in, retry_ok, selftest;
    logic [4:0]  host_addr_in;
    logic [15:0] host_wdata_in, host_rdata_out;
    logic [14:0] ev;
    logic [2:0]  trio;
    logic        irq_out, role_hi, role_lo, mem_sel, halt_cfg, enh, halt;
    int          errors, total_checks;
    iem_host_model i_iem_host_model (.clk_sys_in(clk_sys_in), .host_rdata_in(host_rdata_out),
        .host_addr_out(host_addr_in), .host_wdata_out(host_wdata_in), .host_wr_out(host_wr_in), .host_rd_out(host_rd_in));
    iem_interrupt_config i_iem_interrupt_config
    (
        .clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in), .host_addr_in(host_addr_in), .host_wdata_in(host_wdata_in),
        .host_wr_in(host_wr_in), .host_rd_in(host_rd_in), .host_rdata_out(host_rdata_out),
        .mem_parity_err_in(ev[14]), .transmitter_timeout_in(ev[13]), .cmd_stack_wrap_in(ev[12]),
        .monitor_cmd_wrap_in(ev[11]), .monitor_data_wrap_in(ev[10]), .ext_mem_handshake_fail_in(ev[9]),
        .controller_retry_in(ev[8]), .terminal_addr_parity_fail_in(ev[7]), .timestamp_wrap_in(ev[6]),
        .terminal_ring_wrap_in(ev[5]), .msg_end_in(ev[0] | ev[4]), .ctrlword_msg_end_flag_in(ev[4]),
        .controller_frame_end_in(ev[3]), .msg_error_in(ev[2]), .status_word_mismatch_in(trio[0]),
        .mode_command_in(trio[1] | ev[1]), .trigger_match_in(trio[2]), .selftest_done_in(selftest),
        .retry_success_in(retry_ok), .irq_out(irq_out), .role_select_hi_out(role_hi), .role_select_lo_out(role_lo),
        .memory_location_sel_out(mem_sel), .halt_after_faulty_msg_out(halt_cfg), .enhanced_mode_out(enh),
        .controller_halt_out(halt)
    );
    // ==========================================================
    // Shared helpers
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] want);
        total_checks++;
        if (seen !== want)
        begin
            errors++;
            $display("unexpected %s: expected %h seen %h", what, want, seen);
        end
    endtask : check
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        i_iem_host_model.write_word(a, d);
    endtask : wr
    task automatic rchk(input logic [4:0] a, input logic [15:0] want, input string what);
        logic [15:0] v;
        i_iem_host_model.read_word(a, v);
        check(what, v, want);
    endtask : rchk
    task automatic pulse(input logic [14:0] bits, input logic [2:0] t);
        ev   = bits;
        trio = t;
        @(negedge clk_sys_in);
        ev   = 15'h0000;
        trio = 3'h0;
    endtask : pulse
    // ==========================================================
    // Scenarios
    task automatic t_reset_values;
        check("reset outputs", {irq_out, role_hi, role_lo, enh, halt}, 16'h0008);
        rchk(5'h00, 16'h0000, "mask reset");
        rchk(5'h01, 16'h8000, "config reset");
        rchk(5'h02, 16'h0000, "unmapped read");
        wr(5'h06, 16'hFFFF);
        rchk(5'h06, 16'h0000, "status write ignored");
        wr(5'h00, 16'hFFFF);
        rchk(5'h00, 16'h7FFF, "mask reserved bit");
    endtask : t_reset_values
    // Each event first masked, then released by its own enable bit
    task automatic t_gate_bits;
        logic [15:0] bw;
        for (int b = 0; b < 15; b++)
        begin
            bw = 16'h0001 << b;
            wr(5'h00, 16'h0000);
            pulse(bw[14:0], 3'h0);
            @(negedge clk_sys_in);
            check("masked irq", 16'(irq_out), 16'h0000);
            wr(5'h00, bw);
            check("enabled irq", 16'(irq_out), 16'h0001);
            rchk(5'h06, (b == 4) ? 16'h0011 : bw, "status one");
            check("irq after clear", 16'(irq_out), 16'h0000);
            // Event arriving while already enabled must raise the line itself
            pulse(bw[14:0], 3'h0);
            @(negedge clk_sys_in);
            check("live irq", 16'(irq_out), 16'h0001);
            rchk(5'h06, (b == 4) ? 16'h0011 : bw, "status again");
        end
    endtask : t_gate_bits
    // Only the source of the current mode may set bit 1
    task automatic t_mode_event;
        logic [15:0] modes [3] = '{16'h0000, 16'h8000, 16'hC000};
        for (int m = 0; m < 3; m++)
        begin
            wr(5'h01, modes[m]);
            check("role bits", {role_hi, role_lo}, modes[m][15:14]);
            for (int s = 0; s < 3; s++)
            begin
                pulse(15'h0000, 3'h1 << s);
                rchk(5'h06, (s == m) ? 16'h0002 : 16'h0000, "mode event");
            end
        end
    endtask : t_mode_event
    task automatic t_config;
        wr(5'h01, 16'h7000);
        check("role and fields", {role_hi, role_lo, mem_sel, halt_cfg}, 16'h0003);
        wr(5'h07, 16'h8000);
        check("enhanced on", 16'(enh), 16'h0001);
        wr(5'h01, 16'h8000);
        check("enhanced off", {enh, mem_sel}, 16'h0000);
        wr(5'h07, 16'h0000);
    endtask : t_config
    // Halt waits for a faulty message whose retry did not rescue it
    task automatic t_halt;
        wr(5'h01, 16'h9000);
        pulse(15'h0005, 3'h0);
        @(negedge clk_sys_in);
        check("halt outside controller", 16'(halt), 16'h0000);
        wr(5'h01, 16'h1000);
        retry_ok = 1'b1;
        pulse(15'h0005, 3'h0);
        retry_ok = 1'b0;
        @(negedge clk_sys_in);
        check("halt after good retry", 16'(halt), 16'h0000);
        pulse(15'h0005, 3'h0);
        @(negedge clk_sys_in);
        check("halt after fault", 16'(halt), 16'h0001);
        rchk(5'h06, 16'h0005, "status after halt");
    endtask : t_halt
    task automatic t_selftest;
        pulse(15'h0100, 3'h0);
        rchk(5'h06, 16'h0100, "status retry");
        selftest = 1'b1;
        @(negedge clk_sys_in);
        selftest = 1'b0;
        rchk(5'h1E, 16'h0004, "self-test done");
        rchk(5'h1E, 16'h0000, "self-test cleared");
    endtask : t_selftest
    task automatic close_out;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : close_out
    // ==========================================================
    // Clock, watchdog and main sequence
    initial
    begin
        clk_sys_in = 1'b0;
        forever #25 clk_sys_in = ~clk_sys_in;
    end
    initial
    begin
        #200000;
        errors++;
        close_out();
    end
    initial
    begin
        {arst_n_in, retry_ok, selftest, ev, trio} = '0;
        repeat (6) @(negedge clk_sys_in);
        arst_n_in = 1'b1;
        @(negedge clk_sys_in);
        t_reset_values();
        t_gate_bits();
        t_mode_event();
        t_config();
        t_halt();
        t_selftest();
        close_out();
    end
endmodule : iem_interrupt_config_tb_top
